// *** design/mac_mode_map.vh ***
`ifndef MAC_MODE_MAP_VH
`define MAC_MODE_MAP_VH
// register byte offsets
`define OFS_MODE_CONTROL 12'h000
`define OFS_EVENT_FLAGS 12'h004
`define OFS_IRQ_PERMISSION 12'h008
`define OFS_PATH_STATE 12'h00c
// mode register field positions
`define BIT_CRC_ERROR_ACCEPT 12
`define BIT_WAKE_DETECT_ENABLE 9
`define BIT_RECEIVE_ENABLE 6
`define BIT_TRANSMIT_ENABLE 5
`define BIT_INTERNAL_LOOP 3
`define BIT_EXTERNAL_LOOP 2
`define BIT_DUPLEX 1
`define BIT_ACCEPT_ALL 0
// writable mode bits, reserved bits stay zero
`define MODE_WRITE_MASK 32'h0000126f
// event flag positions (shared with permission bits)
`define BIT_LINK_CHANGE 2
`define BIT_WAKE_SEEN 1
`define BIT_BAD_CARRIER 0
`define FLAG_WIDTH 3
// reset values
`define MODE_RESET 32'h00000000
`define FLAGS_RESET 3'h0
`define PERMIT_RESET 3'h0
`endif

// *** design/sync_two_stage.v ***
`timescale 1ns/1ps
`default_nettype none
// two flip-flop level synchroniser
module sync_two_stage (
  input wire clk, // system clock
  input wire reset, // async reset, active high
  input wire asyncIn, // level from outside the clock domain
  output reg syncOut_ff // synchronised level
);
  reg stage1_ff;

  // first stage feeds only the second
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1_ff <= 1'b0;
      syncOut_ff <= 1'b0;
    end else begin
      stage1_ff <= asyncIn;
      syncOut_ff <= stage1_ff;
    end
  end
endmodule // sync_two_stage
`default_nettype wire

// *** design/mac_mode_status_control.v ***
// Functional notes
// - crc-error frames flagged unless accept bit set
// - crc error counter pulses on every crc error
// - wake detect enable sets flag, drives wake pin
// - receiver stays active until current frame ends
// - transmitter stays active until current frame sent
// - internal loopback select when bit set
// - external loop bit drives general output pin
// - duplex bit selects half or full, half at reset
// - accept all frames ignores address filtering
// - reserved mode bits read zero, written zero
// - writing one clears a flag, zero keeps it
// - link change flag on either link edge
// - wake seen flag on detected wake packet
// - bad carrier flag on phy illegal carrier report
// - flag interrupts only when permission bit set
// - reserved flag bits read zero
// - link change detected only when pin routed
// - link status sampled, current level is source
// - permission bits 2,1,0 gate the three flags
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "mac_mode_map.vh"
module mac_mode_status_control (
  input wire clk, // system clock, 25 MHz
  input wire reset, // async reset, active high
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction, high for write
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata_ff, // apb read data
  output reg pready_ff, // apb ready
  output reg pslverr_ff, // apb error on unmapped address
  input wire rxFrameBusy, // receiver is inside a frame
  input wire txFrameBusy, // transmitter is inside a frame
  input wire rxFrameEnd, // pulse, received frame finished
  input wire rxCrcBad, // crc result of ending frame, with rxFrameEnd
  input wire wakePacketHit, // pulse, receiver matched a wake packet
  input wire linkPinRouted, // pin multiplexer routes link status
  input wire link_status_in, // link status pin from phy
  input wire badCarrierIn, // illegal carrier indication pin from phy
  output reg receiveActive_ff, // receiver running
  output reg transmitActive_ff, // transmitter running
  output reg rxFrameError_ff, // pulse, frame rejected for crc error
  output reg crcCountInc_ff, // pulse, bump crc error frame counter
  output reg internalLoop_ff, // loop tx data into rx
  output reg general_output_pin_ff, // external loop directive pin
  output reg fullDuplex_ff, // full duplex selected
  output reg acceptAll_ff, // promiscuous reception
  output reg wakeDetectOn_ff, // wake packet detector enabled
  output reg wake_output_ff, // wake pin toward peripheral chips
  output reg linkLevel_ff, // current sampled link level
  output reg irqOut_ff // interrupt request, active high
);
  reg [31:0] mode_ff;
  reg [`FLAG_WIDTH-1:0] flags_ff;
  reg [`FLAG_WIDTH-1:0] permit_ff;
  reg linkPrev_ff;
  reg linkPrevValid_ff;
  reg [`FLAG_WIDTH-1:0] nxt_flags;
  reg [31:0] nxt_rdata;
  reg nxt_err;
  wire linkSync;
  wire carrierSync;
  wire setupPhase;
  wire accessDone;
  wire writeDone;
  wire linkEdge;
  wire [`FLAG_WIDTH-1:0] flagSet;
  wire [`FLAG_WIDTH-1:0] flagClear;

  // pin inputs pass two flip-flops first
  sync_two_stage linkSyncInst (
    .clk(clk),
    .reset(reset),
    .asyncIn(link_status_in),
    .syncOut_ff(linkSync)
  );
  sync_two_stage carrierSyncInst (
    .clk(clk),
    .reset(reset),
    .asyncIn(badCarrierIn),
    .syncOut_ff(carrierSync)
  );

  // apb phase decode
  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & pready_ff;
  assign writeDone = accessDone & pwrite & ~pslverr_ff;

  // link edge, only while link pin is routed
  assign linkEdge = linkPrevValid_ff & (linkSync != linkPrev_ff) & linkPinRouted;

  // hardware events that set flags
  assign flagSet[`BIT_LINK_CHANGE] = linkEdge;
  assign flagSet[`BIT_WAKE_SEEN] = wakePacketHit & mode_ff[`BIT_WAKE_DETECT_ENABLE];
  assign flagSet[`BIT_BAD_CARRIER] = carrierSync;

  // write-one-to-clear from software
  assign flagClear = (writeDone && paddr == `OFS_EVENT_FLAGS) ? pwdata[`FLAG_WIDTH-1:0] : `FLAGS_RESET;

  // flag update, set wins over clear
  always @* begin
    nxt_flags = (flags_ff & ~flagClear) | flagSet;
  end

  // read mux and address check
  always @* begin
    nxt_rdata = 32'h00000000;
    nxt_err = 1'b0;
    case (paddr)
      `OFS_MODE_CONTROL: begin
        nxt_rdata = mode_ff & `MODE_WRITE_MASK;
      end
      `OFS_EVENT_FLAGS: begin
        nxt_rdata = {29'h0000000, flags_ff};
      end
      `OFS_IRQ_PERMISSION: begin
        nxt_rdata = {29'h0000000, permit_ff};
      end
      `OFS_PATH_STATE: begin
        nxt_rdata = {29'h0000000, linkLevel_ff, transmitActive_ff, receiveActive_ff};
      end
      default: begin
        nxt_err = 1'b1;
      end
    endcase
  end

  // apb slave: ready one cycle after setup
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else if (setupPhase) begin
      pready_ff <= 1'b1;
      pslverr_ff <= nxt_err;
      prdata_ff <= pwrite ? 32'h00000000 : nxt_rdata;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end
  end

  // software registers
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_ff <= `MODE_RESET;
      permit_ff <= `PERMIT_RESET;
    end else if (writeDone) begin
      if (paddr == `OFS_MODE_CONTROL) begin
        mode_ff <= pwdata & `MODE_WRITE_MASK;
      end
      if (paddr == `OFS_IRQ_PERMISSION) begin
        permit_ff <= pwdata[`FLAG_WIDTH-1:0];
      end
    end
  end

  // event flags and link history
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      flags_ff <= `FLAGS_RESET;
      linkPrev_ff <= 1'b0;
      linkPrevValid_ff <= 1'b0;
      linkLevel_ff <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      linkPrev_ff <= linkSync;
      linkPrevValid_ff <= 1'b1;
      linkLevel_ff <= linkSync;
    end
  end

  // gated interrupt request
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      irqOut_ff <= 1'b0;
    end else begin
      irqOut_ff <= |(nxt_flags & permit_ff);
    end
  end

  // path enables hold to end of current frame
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      receiveActive_ff <= 1'b0;
      transmitActive_ff <= 1'b0;
    end else begin
      receiveActive_ff <= mode_ff[`BIT_RECEIVE_ENABLE] | (receiveActive_ff & rxFrameBusy);
      transmitActive_ff <= mode_ff[`BIT_TRANSMIT_ENABLE] | (transmitActive_ff & txFrameBusy);
    end
  end

  // crc error handling of finished frames
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rxFrameError_ff <= 1'b0;
      crcCountInc_ff <= 1'b0;
    end else begin
      rxFrameError_ff <= rxFrameEnd & rxCrcBad & ~mode_ff[`BIT_CRC_ERROR_ACCEPT];
      crcCountInc_ff <= rxFrameEnd & rxCrcBad;
    end
  end

  // mode outputs toward datapath and pins
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      internalLoop_ff <= 1'b0;
      general_output_pin_ff <= 1'b0;
      fullDuplex_ff <= 1'b0;
      acceptAll_ff <= 1'b0;
      wakeDetectOn_ff <= 1'b0;
      wake_output_ff <= 1'b0;
    end else begin
      internalLoop_ff <= mode_ff[`BIT_INTERNAL_LOOP];
      general_output_pin_ff <= mode_ff[`BIT_EXTERNAL_LOOP];
      fullDuplex_ff <= mode_ff[`BIT_DUPLEX];
      acceptAll_ff <= mode_ff[`BIT_ACCEPT_ALL];
      wakeDetectOn_ff <= mode_ff[`BIT_WAKE_DETECT_ENABLE];
      wake_output_ff <= nxt_flags[`BIT_WAKE_SEEN];
    end
  end
endmodule // mac_mode_status_control
`default_nettype wire

// *** tb/phy_side_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// phy side: link level and illegal carrier pins
module phy_side_model (
  input wire logic clk, // system clock
  output var logic linkUp, // link status level
  output var logic badCarrier // illegal carrier report
);
  // pins idle low from time zero
  initial begin
    linkUp = 1'b0;
    badCarrier = 1'b0;
  end
  // one link edge, launched after a clock edge
  task automatic link_flip();
    @(posedge clk);
    linkUp <= ~linkUp;
  endtask
  // illegal carrier report held for three cycles
  task automatic carrier_burst();
    @(posedge clk);
    badCarrier <= 1'b1;
    repeat (3) @(posedge clk);
    badCarrier <= 1'b0;
  endtask
endmodule // phy_side_model
`default_nettype wire

// *** tb/mac_mode_status_control_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mac_mode_map.vh"
// port watcher for the mode and flag block
module mac_mode_status_control_sva (
  input wire logic clk, // clock
  input wire logic reset, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [11:0] paddr, // apb
  input wire logic [31:0] pwdata, // apb
  input wire logic [31:0] prdata_ff, // apb
  input wire logic pready_ff, // apb
  input wire logic pslverr_ff, // apb
  input wire logic rxFrameBusy, // rx frame
  input wire logic rxFrameEnd, // rx end
  input wire logic rxCrcBad, // crc bad
  input wire logic receiveActive_ff, // rx on
  input wire logic rxFrameError_ff, // rx error
  input wire logic crcCountInc_ff, // crc count
  input wire logic general_output_pin_ff, // loop pin
  input wire logic fullDuplex_ff // duplex
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // access decodes
  wire logic acc = psel && penable && pready_ff;
  wire logic wrMode = acc && pwrite && paddr == `OFS_MODE_CONTROL;
  sequence setupPhase;
    psel && !penable;
  endsequence
  a_setup_ready: assert property (setupPhase |=> pready_ff)
    else $error("no ready after setup");
  a_ready_single: assert property (pready_ff |=> !pready_ff)
    else $error("ready held too long");
  a_mode_rsvd: assert property (acc && !pwrite && paddr == `OFS_MODE_CONTROL |->
    (prdata_ff & ~`MODE_WRITE_MASK) == 32'h0) else $error("reserved mode bit set");
  a_flag_rsvd: assert property (acc && !pwrite && paddr == `OFS_EVENT_FLAGS |->
    prdata_ff[31:3] == 29'h0) else $error("reserved flag bit set");
  a_ext_loop_pin: assert property (wrMode |-> ##2 general_output_pin_ff == $past(pwdata[2], 2))
    else $error("loop pin wrong");
  a_duplex_follow: assert property (wrMode |-> ##2 fullDuplex_ff == $past(pwdata[1], 2))
    else $error("duplex wrong");
  a_rx_frame_hold: assert property (receiveActive_ff && rxFrameBusy |=> receiveActive_ff)
    else $error("receiver dropped in frame");
  a_crc_count_bump: assert property (rxFrameEnd && rxCrcBad |=> crcCountInc_ff)
    else $error("crc count missed");
  a_crc_err_cause: assert property (rxFrameError_ff |-> $past(rxFrameEnd && rxCrcBad))
    else $error("frame error without crc error");
  a_unmapped_err: assert property (pready_ff && paddr > `OFS_PATH_STATE |-> pslverr_ff && prdata_ff == 32'h0)
    else $error("unmapped access not refused");
endmodule // mac_mode_status_control_sva
bind mac_mode_status_control mac_mode_status_control_sva sva (.*);
`default_nettype wire

// *** tb/test_mac_mode_status_control.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mac_mode_map.vh"
module test_mac_mode_status_control;
  logic clk, reset, psel, penable, pwrite, rxFrameBusy, txFrameBusy, rxFrameEnd, rxCrcBad, e;
  logic wakePacketHit, linkPinRouted, pslverr_ff, pready_ff, receiveActive_ff, transmitActive_ff;
  logic rxFrameError_ff, crcCountInc_ff, internalLoop_ff, general_output_pin_ff, fullDuplex_ff;
  logic acceptAll_ff, wakeDetectOn_ff, wake_output_ff, linkLevel_ff, irqOut_ff, link_status_in, badCarrierIn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_ff, r;
  int error_cnt = 0, n_compared = 0;
  mac_mode_status_control dut (.*);
  phy_side_model phy (.clk(clk), .linkUp(link_status_in), .badCarrier(badCarrierIn));
  // 25 MHz clock
  initial clk = 1'b0;
  always #20 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready_ff !== 1'b1);
    r = prdata_ff;
    e = pslverr_ff;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0);
    chk("read", x, r);
  endtask
  // one ending frame with bad crc
  task automatic crc(input logic [31:0] x);
    @(posedge clk);
    {rxFrameEnd, rxCrcBad} <= 2'b11;
    @(posedge clk);
    {rxFrameEnd, rxCrcBad} <= 2'b00;
    #1 chk("crc", x, 32'({rxFrameError_ff, crcCountInc_ff}));
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard
  initial begin
    #400000;
    error_cnt++;
    final_report();
  end
  initial begin
    {psel, penable, pwrite, rxFrameBusy, txFrameBusy, rxFrameEnd, rxCrcBad, wakePacketHit, linkPinRouted} = '0;
    {paddr, pwdata} = '0;
    reset = 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd(`OFS_MODE_CONTROL, `MODE_RESET);
    rd(`OFS_EVENT_FLAGS, 32'h0);
    chk("outs", 32'h0, 32'({wake_output_ff, irqOut_ff, receiveActive_ff, general_output_pin_ff}));
    apb(`OFS_MODE_CONTROL, 1'b1, 32'hffffffff);
    rd(`OFS_MODE_CONTROL, `MODE_WRITE_MASK);
    chk("pins", 32'h1f, 32'({internalLoop_ff, general_output_pin_ff, fullDuplex_ff, acceptAll_ff, wakeDetectOn_ff}));
    apb(`OFS_MODE_CONTROL, 1'b1, 32'h0);
    rd(`OFS_MODE_CONTROL, 32'h0);
    chk("pins", 32'h0, 32'({internalLoop_ff, general_output_pin_ff, fullDuplex_ff, acceptAll_ff, wakeDetectOn_ff}));
    apb(12'h010, 1'b1, 32'h1);
    chk("slverr", 32'h1, 32'(e));
    rd(12'h010, 32'h0);
    chk("slverr", 32'h1, 32'(e));
    // paths kept alive through a frame
    apb(`OFS_MODE_CONTROL, 1'b1, 32'h60);
    {rxFrameBusy, txFrameBusy} <= 2'b11;
    apb(`OFS_MODE_CONTROL, 1'b1, 32'h0);
    rd(`OFS_PATH_STATE, 32'h3);
    repeat (3) @(posedge clk);
    chk("busy", 32'h3, 32'({transmitActive_ff, receiveActive_ff}));
    {rxFrameBusy, txFrameBusy} <= 2'b00;
    repeat (3) @(posedge clk);
    chk("idle", 32'h0, 32'({transmitActive_ff, receiveActive_ff}));
    crc(32'h3);
    apb(`OFS_MODE_CONTROL, 1'b1, 32'h1000);
    crc(32'h1);
    // link edges both ways
    linkPinRouted <= 1'b1;
    apb(`OFS_IRQ_PERMISSION, 1'b1, 32'h7);
    rd(`OFS_IRQ_PERMISSION, 32'h7);
    for (int i = 0; i < 2; i++) begin
      phy.link_flip();
      repeat (4) @(posedge clk);
      rd(`OFS_EVENT_FLAGS, 32'h4);
      chk("irq", 32'h1, 32'(irqOut_ff));
      chk("level", 32'(link_status_in), 32'(linkLevel_ff));
      apb(`OFS_EVENT_FLAGS, 1'b1, 32'h3);
      rd(`OFS_EVENT_FLAGS, 32'h4);
      apb(`OFS_EVENT_FLAGS, 1'b1, 32'h4);
      rd(`OFS_EVENT_FLAGS, 32'h0);
    end
    apb(`OFS_MODE_CONTROL, 1'b1, 32'h200);
    @(posedge clk);
    wakePacketHit <= 1'b1;
    @(posedge clk);
    wakePacketHit <= 1'b0;
    repeat (2) @(posedge clk);
    rd(`OFS_EVENT_FLAGS, 32'h2);
    chk("wake", 32'h1, 32'(wake_output_ff));
    apb(`OFS_IRQ_PERMISSION, 1'b1, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, 32'(irqOut_ff));
    apb(`OFS_EVENT_FLAGS, 1'b1, 32'h2);
    rd(`OFS_EVENT_FLAGS, 32'h0);
    chk("wake", 32'h0, 32'(wake_output_ff));
    phy.carrier_burst();
    repeat (3) @(posedge clk);
    rd(`OFS_EVENT_FLAGS, 32'h1);
    apb(`OFS_EVENT_FLAGS, 1'b1, 32'h1);
    linkPinRouted <= 1'b0;
    phy.link_flip();
    repeat (5) @(posedge clk);
    rd(`OFS_EVENT_FLAGS, 32'h0);
    // mid-run reset clears the wake enable left set above
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(`OFS_MODE_CONTROL, `MODE_RESET);
    chk("outs", 32'h0, 32'({wake_output_ff, wakeDetectOn_ff, transmitActive_ff, receiveActive_ff}));
    final_report();
  end
endmodule // test_mac_mode_status_control
`default_nettype wire
